// ### dpr_defines.svh
// Constants for the power-down/reset sequencer pair.
// Assumes inclusion by bare name from the same folder.
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define DPR_CLK_PERIOD_NS 8
`define DPR_MIN_LOW_CYCLES 4
`define DPR_LOCK_WAIT_MS 100
`define DPR_LOCK_WAIT_CYCLES ((`DPR_LOCK_WAIT_MS * 1000000) / `DPR_CLK_PERIOD_NS)
`define DPR_RESET_OP_CYCLES 8

// ****************************************
// Channel control word layout and defaults
// ****************************************
`define DPR_CTRL_MUTE_BIT 6
`define DPR_CTRL_ATTEN_MSB 5
`define DPR_CTRL_MUTE_RST 1'b0
`define DPR_CTRL_ATTEN_RST 6'h00

`endif

// ### dpr_pkg.sv
// Types shared by both ends of the power-down/reset link.
// Assumes dpr_defines.svh sits in the same folder.
`default_nettype none
package dpr_pkg;
  // Device sequencer states
  typedef enum logic [3:0] {
    DPR_ST_DOWN = 4'h1,
    DPR_ST_RESET = 4'h2,
    DPR_ST_READY = 4'h4,
    DPR_ST_IDLE = 4'h8
  } dpr_dev_state_t;

  // Host sequencer states
  typedef enum logic [3:0] {
    DPR_HS_HOLD = 4'h1,
    DPR_HS_WAIT = 4'h2,
    DPR_HS_RUN = 4'h4,
    DPR_HS_OFF = 4'h8
  } dpr_host_state_t;

  // One channel control word
  typedef struct packed {
    logic mute;
    logic [5:0] atten;
  } dpr_chan_ctrl_t;
endpackage
`default_nettype wire

// ### dpr_link_if.sv
// Pins between host and device: reset line and format selects.
// Assumes both ends run from the same master clock.
`timescale 1ns/1ps
`default_nettype none
interface dpr_link_if;
  logic power_down_reset_n;
  logic input_format_sel0;
  logic input_format_sel1;
  logic word_length_sel;
  logic deemphasis_sel;

  modport host (
    output power_down_reset_n, input_format_sel0, input_format_sel1,
    output word_length_sel, deemphasis_sel
  );
  modport device (
    input power_down_reset_n, input_format_sel0, input_format_sel1,
    input word_length_sel, deemphasis_sel
  );
endinterface
`default_nettype wire

// ### dpr_device.sv
// Device end: power-down and reset sequencing of the DAC core.
// Assumes pins arrive asynchronously; clk is the master clock.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defines.svh"
module dpr_device
  import dpr_pkg::*;
#(
  parameter int MIN_LOW = `DPR_MIN_LOW_CYCLES,
  parameter int RESET_OP = `DPR_RESET_OP_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Link to host
  dpr_link_if.device link,
  // Channel control writes from the control port
  input wire logic ctrl_wr,
  input wire logic ctrl_right,
  input wire logic [6:0] ctrl_word,
  // Status and core controls
  output logic power_down,
  output logic engine_clear,
  output logic amp_short,
  output logic ready,
  output logic [6:0] left_ctrl,
  output logic [6:0] right_ctrl,
  output logic [3:0] format_sel
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] rst_sync_q;
  logic rst_level_q;
  logic [3:0] fmt_s1_q, fmt_s2_q, fmt_s3_q;
  wire [3:0] fmt_pins = {link.deemphasis_sel, link.word_length_sel,
                         link.input_format_sel1, link.input_format_sel0};
  wire rst_agree = (rst_sync_q[1] == rst_sync_q[2]);

  // Reset line: level changes once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_sync_q <= 3'h0;
      rst_level_q <= 1'b0;
    end else if (ce) begin
      rst_sync_q <= {rst_sync_q[1:0], link.power_down_reset_n};
      if (rst_agree) rst_level_q <= rst_sync_q[2];
    end
  end

  // Format pins: same three-stage chain, one lane per pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt_s1_q <= 4'h0;
      fmt_s2_q <= 4'h0;
      fmt_s3_q <= 4'h0;
    end else if (ce) begin
      fmt_s1_q <= fmt_pins;
      fmt_s2_q <= fmt_s1_q;
      fmt_s3_q <= fmt_s2_q;
    end
  end

  // Format selects follow agreed samples only
  logic [3:0] fmt_q;
  wire [3:0] fmt_agree = ~(fmt_s2_q ^ fmt_s3_q);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_fmt
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          fmt_q[g] <= 1'b0;
        end else if (ce && fmt_agree[g]) begin
          fmt_q[g] <= fmt_s3_q[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Low-time qualifier and sequencer
  // ****************************************
  logic [3:0] low_cnt_q;
  logic [7:0] op_cnt_q;
  dpr_dev_state_t state_q, state_d;
  wire low_ok = (low_cnt_q >= 4'(MIN_LOW));
  wire op_done = (op_cnt_q >= 8'(RESET_OP - 1));

  // Count consecutive low samples of the agreed level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_q <= 4'h0;
    end else if (ce) begin
      if (rst_level_q) low_cnt_q <= 4'h0;
      else if (!low_ok) low_cnt_q <= low_cnt_q + 4'h1;
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      DPR_ST_IDLE: if (!rst_level_q && low_ok) state_d = DPR_ST_DOWN;
      DPR_ST_DOWN: if (rst_level_q) state_d = DPR_ST_RESET;
      DPR_ST_RESET: if (op_done) state_d = DPR_ST_READY;
      DPR_ST_READY: if (!rst_level_q && low_ok) state_d = DPR_ST_DOWN;
      default: state_d = DPR_ST_DOWN;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= DPR_ST_DOWN;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Reset-operation length, cleared outside the reset state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_cnt_q <= 8'h00;
    end else if (ce) begin
      op_cnt_q <= (state_q == DPR_ST_RESET) ? op_cnt_q + 8'h01 : 8'h00;
    end
  end

  // ****************************************
  // Outputs and channel control words
  // ****************************************
  wire in_down = (state_d == DPR_ST_DOWN);
  wire in_reset = (state_d == DPR_ST_RESET);
  wire in_ready = (state_d == DPR_ST_READY);
  wire hold_core = in_down | in_reset;
  wire ctrl_take = ctrl_wr & ready;
  wire [1:0] chan_hit = {ctrl_right, ~ctrl_right};
  wire [6:0] ctrl_dflt = {`DPR_CTRL_MUTE_RST, `DPR_CTRL_ATTEN_RST};

  // Power-down flag follows the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_down <= 1'b1;
    end else if (ce) begin
      power_down <= in_down;
    end
  end

  // Engine held cleared through power-down and reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      engine_clear <= 1'b1;
    end else if (ce) begin
      engine_clear <= hold_core;
    end
  end

  // Amplifiers shorted so the release makes no click
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amp_short <= 1'b1;
    end else if (ce) begin
      amp_short <= hold_core;
    end
  end

  // Ready once the reset operation is over
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else if (ce) begin
      ready <= in_ready;
    end
  end

  // Agreed format selects handed to the data port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      format_sel <= 4'h0;
    end else if (ce) begin
      format_sel <= fmt_q;
    end
  end

  // Channel control words; writes land only while ready
  logic [6:0] chan_q [2];
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          chan_q[c] <= 7'h00;
        end else if (ce) begin
          if (hold_core) chan_q[c] <= ctrl_dflt;
          else if (ctrl_take && chan_hit[c]) chan_q[c] <= ctrl_word;
        end
      end
    end
  endgenerate

  // Channel 0 is left, channel 1 is right
  assign left_ctrl = chan_q[0];
  assign right_ctrl = chan_q[1];
endmodule
`default_nettype wire

// ### dpr_host.sv
// Host end: drives the reset line and format selects.
// Assumes the device samples the pins on the same master clock.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defines.svh"
module dpr_host
  import dpr_pkg::*;
#(
  parameter int HOLD_CYCLES = `DPR_MIN_LOW_CYCLES,
  parameter int LOCK_CYCLES = `DPR_LOCK_WAIT_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // User requests
  input wire logic pd_req,
  input wire logic [3:0] fmt_req,
  // Link to device
  dpr_link_if.host link,
  // Status
  output logic ports_ok
);

  // ****************************************
  // Sequencer
  // ****************************************
  dpr_host_state_t state_q, state_d;
  logic [23:0] cnt_q;
  logic pin_q;
  logic [3:0] fmt_q;
  wire hold_done = (cnt_q >= 24'(HOLD_CYCLES - 1));
  wire lock_done = (cnt_q >= 24'(LOCK_CYCLES - 1));

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      DPR_HS_HOLD: if (hold_done) state_d = pd_req ? DPR_HS_OFF : DPR_HS_WAIT;
      DPR_HS_OFF: if (!pd_req) state_d = DPR_HS_WAIT;
      DPR_HS_WAIT: if (lock_done) state_d = DPR_HS_RUN;
      DPR_HS_RUN: if (pd_req) state_d = DPR_HS_HOLD;
      default: state_d = DPR_HS_HOLD;
    endcase
  end

  // Counter restarts on every state change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= DPR_HS_HOLD;
      cnt_q <= 24'h000000;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 24'h000000 : cnt_q + 24'h000001;
    end
  end

  // Pins: low while holding or off; formats follow fmt_req in every state except run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
      fmt_q <= 4'h0;
      ports_ok <= 1'b0;
    end else if (ce) begin
      pin_q <= (state_d == DPR_HS_WAIT) || (state_d == DPR_HS_RUN);
      if (state_d != DPR_HS_RUN) fmt_q <= fmt_req;
      ports_ok <= (state_d == DPR_HS_RUN);
    end
  end

  // Clock stays with device: host runs on the same clock
  assign link.power_down_reset_n = pin_q;
  assign link.input_format_sel0 = fmt_q[0];
  assign link.input_format_sel1 = fmt_q[1];
  assign link.word_length_sel = fmt_q[2];
  assign link.deemphasis_sel = fmt_q[3];
endmodule
`default_nettype wire

// ### dpr_link_chk.sv
// Checker for the reset link and device status.
// Assumes instantiation beside the link interface in the bench.
`timescale 1ns/1ps
`default_nettype none
module dpr_link_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched signals
  input wire logic power_down_reset_n,
  input wire logic power_down,
  input wire logic engine_clear,
  input wire logic amp_short,
  input wire logic ready,
  input wire logic ports_ok,
  input wire logic [6:0] left_ctrl,
  input wire logic [6:0] right_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Sequencing
  // ****
  pd_enter_a: assert property (!power_down_reset_n [*8] ##1 !power_down_reset_n [*3]
    |-> power_down) else $error("power down missed");
  pd_exit_a: assert property (power_down_reset_n [*8] ##1 power_down_reset_n
    |-> !power_down) else $error("power down stuck");
  ready_keep_a: assert property (power_down_reset_n [*8] ##1 (power_down_reset_n && ready)
    |=> ready) else $error("ready dropped");
  clear_hold_a: assert property ($fell(power_down)
    |-> (engine_clear && amp_short) [*7]) else $error("clear too short");
  ready_after_a: assert property ($fell(power_down) |-> ##[7:12] ready)
    else $error("ready late");
  clear_busy_a: assert property (engine_clear |-> !ready) else $error("ready in reset");
  pd_short_a: assert property (power_down |-> amp_short && engine_clear)
    else $error("amps open");
  dflt_ctrl_a: assert property ($rose(ready) |-> left_ctrl == 7'h00 && right_ctrl == 7'h00)
    else $error("ctrl not default");
  lock_wait_a: assert property ($rose(power_down_reset_n) |-> !ports_ok [*8])
    else $error("ports early");
endmodule
`default_nettype wire

// ### dac_power_down_reset_ctrl_tb.sv
// Bench joining host and device ends through the link.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dac_power_down_reset_ctrl_tb;
  import dpr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, pd_req = 1'b0, ctrl_wr = 1'b0, ctrl_right = 1'b0;
  logic [3:0] fmt_req = 4'h0;
  logic [6:0] ctrl_word = 7'h00;
  logic power_down, engine_clear, amp_short, ready, ports_ok;
  logic [6:0] left_ctrl, right_ctrl;
  logic [3:0] format_sel;
  logic [6:0] model [2] = '{7'h00, 7'h00};
  integer seed = 32'hf19cd88a;
  int err_count = 0, checked = 0, cyc = 0, n;
  dpr_link_if link ();
  // ****
  // Design and checker
  // ****
  dpr_host #(.LOCK_CYCLES(50)) dpr_host_i (.clk(clk), .rst(rst), .ce(ce), .pd_req(pd_req),
    .fmt_req(fmt_req), .link(link), .ports_ok(ports_ok));
  dpr_device dpr_device_i (.clk(clk), .rst(rst), .ce(ce), .link(link), .ctrl_wr(ctrl_wr),
    .ctrl_right(ctrl_right), .ctrl_word(ctrl_word), .power_down(power_down),
    .engine_clear(engine_clear), .amp_short(amp_short), .ready(ready),
    .left_ctrl(left_ctrl), .right_ctrl(right_ctrl), .format_sel(format_sel));
  dpr_link_chk dpr_link_chk_i (.clk(clk), .rst(rst),
    .power_down_reset_n(link.power_down_reset_n), .power_down(power_down),
    .engine_clear(engine_clear), .amp_short(amp_short), .ready(ready),
    .ports_ok(ports_ok), .left_ctrl(left_ctrl), .right_ctrl(right_ctrl));
  // Clock at 125 MHz
  initial begin
    forever #4 clk = ~clk;
  end
  // Compare and report
  task chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task final_report;
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded wait: 0 ready, 1 power_down, 2 ports_ok
  task wait_hi(input int s);
    logic [2:0] v;
    n = 0;
    v = {ports_ok, power_down, ready};
    while (v[s] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
      v = {ports_ok, power_down, ready};
    end
    chk("wait", 7'h01, {6'h00, v[s]});
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report;
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    wait_hi(0);
    chk("power_down", 7'h00, {6'h00, power_down});
    chk("ports_ok", 7'h00, {6'h00, ports_ok});
    chk("left", model[0], left_ctrl);
    chk("right", model[1], right_ctrl);
    wait_hi(2);
    // Random writes to both channels
    for (int i = 0; i < 8; i++) begin
      ctrl_word = 7'($random(seed));
      ctrl_right = i[0];
      ctrl_wr = 1'b1;
      model[i % 2] = ctrl_word;
      @(negedge clk);
      ctrl_wr = 1'b0;
      @(negedge clk);
      chk("left", model[0], left_ctrl);
      chk("right", model[1], right_ctrl);
    end
    // Clock enable low: a write is frozen out, state holds
    ce = 1'b0;
    ctrl_word = 7'($random(seed));
    ctrl_right = 1'b0;
    ctrl_wr = 1'b1;
    repeat (3) @(negedge clk);
    chk("left", model[0], left_ctrl);
    chk("right", model[1], right_ctrl);
    chk("ready", 7'h01, {6'h00, ready});
    chk("ports_ok", 7'h01, {6'h00, ports_ok});
    ctrl_wr = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    chk("left", model[0], left_ctrl);
    // Power down, write ignored, new formats, then reset defaults
    pd_req = 1'b1;
    fmt_req = 4'($random(seed));
    wait_hi(1);
    chk("ready", 7'h00, {6'h00, ready});
    chk("clear", 7'h03, {5'h00, engine_clear, amp_short});
    chk("ports_ok", 7'h00, {6'h00, ports_ok});
    ctrl_word = 7'h7f;
    ctrl_wr = 1'b1;
    @(negedge clk);
    ctrl_wr = 1'b0;
    pd_req = 1'b0;
    model = '{7'h00, 7'h00};
    wait_hi(0);
    chk("left", model[0], left_ctrl);
    chk("right", model[1], right_ctrl);
    chk("format", {3'h0, fmt_req}, {3'h0, format_sel});
    final_report;
  end
endmodule
`default_nettype wire
